// File: hw/icct_timer.sv
`timescale 1ns/1ps
`default_nettype none
module icct_timer #(
    parameter int N_TRIG = 16
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [icct_pkg::ADDR_W-1:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd
    input wire logic [N_TRIG-1:0] capture_trigger_input, // Trigger pins
    input wire logic sleep_en, // Sleep request from power unit
    output logic sleep_ok, // Block may enter low power
    output logic match_output_zero, // Compare 0 toggle output
    output logic match_output_one, // Compare 1 toggle output
    output icct_pkg::icct_evt_s events // Event pulses
);
    import icct_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (N_TRIG < 1 || N_TRIG > (1 << MUX_W)) begin : g_bad
        $error("N_TRIG out of range for route select width");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CTL_W-1:0] ctl_ff;
    logic [CAPCTL_W-1:0] capctl_ff [N_CAP];
    logic [MUX_W*N_CAP-1:0] route_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] cap_ff [N_CAP];
    logic [CNT_W-1:0] cmp_ff [N_CMP];
    logic [N_CMP-1:0] tgl_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [31:0] rdata_ff;
    icct_evt_s evt_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic wr_ctl = wr && (addr == OFS_CTL);
    wire logic wr_capctl0 = wr && (addr == OFS_CAPCTL0);
    wire logic wr_capctl1 = wr && (addr == OFS_CAPCTL1);
    wire logic wr_frt = wr && (addr == OFS_FRT);
    wire logic wr_cmp0 = wr && (addr == OFS_CMP0);
    wire logic wr_cmp1 = wr && (addr == OFS_CMP1);
    wire logic wr_mux = wr && (addr == OFS_MUX);
    wire logic in_cap = (addr >= OFS_CAP0) && (addr <= OFS_CAP5);
    wire logic [ADDR_W-1:0] cap_ofs = addr - OFS_CAP0;
    wire logic [2:0] cap_idx = cap_ofs[4:2];

    // Block state seen by counter and power unit
    wire logic active = ctl_ff[CTL_ACT] && !sleep_en;
    wire logic run = active && ctl_ff[CTL_CNT_EN]; // RULE19
    wire logic wrap = run && (cnt_ff == {CNT_W{1'b1}}); // RULE5
    wire logic [CNT_W-1:0] cnt_inc = cnt_ff + 32'h0000_0001;

    // Low power is granted only while idle
    assign sleep_ok = !ctl_ff[CTL_ACT] || sleep_en; // RULE13

    // ------------------------------------------------------------
    // Free-running counter
    // ------------------------------------------------------------
    // Counter is never cleared by sleep; it simply holds while idle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0; // RULE12
        end else if (wr_frt) begin
            cnt_ff <= wdata;
        end else if (run) begin
            cnt_ff <= cnt_inc; // RULE1 RULE14
        end
    end

    // ------------------------------------------------------------
    // Control, routing and compare registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_ff <= '0;
            route_ff <= '0;
            cmp_ff[0] <= '0;
            cmp_ff[1] <= '0;
        end else begin
            if (wr_ctl) begin
                ctl_ff <= wdata[CTL_W-1:0];
            end
            if (wr_mux) begin
                route_ff <= wdata[MUX_W*N_CAP-1:0]; // RULE8
            end
            if (wr_cmp0) begin
                cmp_ff[0] <= wdata;
            end
            if (wr_cmp1) begin
                cmp_ff[1] <= wdata;
            end
        end
    end

    // Capture control: four channels in the first word, two in next
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < N_CAP; i++) begin
                capctl_ff[i] <= CAPCTL_RST;
            end
        end else begin
            for (int i = 0; i < CAPS_PER_REG; i++) begin
                if (wr_capctl0) begin
                    capctl_ff[i] <= wdata[i*CAPCTL_W +: CAPCTL_W];
                end
            end
            for (int i = CAPS_PER_REG; i < N_CAP; i++) begin
                if (wr_capctl1) begin
                    capctl_ff[i] <=
                        wdata[(i-CAPS_PER_REG)*CAPCTL_W +: CAPCTL_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Compare matchers and toggle outputs
    // ------------------------------------------------------------
    // Matching is gated by run so a stopped counter cannot fire the
    // same match every cycle.
    logic [N_CMP-1:0] cmp_en;
    logic [N_CMP-1:0] match;
    logic [N_CMP-1:0] set_w;
    logic [N_CMP-1:0] clr_w;
    assign cmp_en = {ctl_ff[CTL_CMP_EN1], ctl_ff[CTL_CMP_EN0]};
    assign match[0] = run && cmp_en[0] && (cnt_ff == cmp_ff[0]); // RULE6 RULE18
    assign match[1] = run && cmp_en[1] && (cnt_ff == cmp_ff[1]); // RULE7 RULE18
    assign set_w = wr_ctl ? {wdata[CTL_SET1], wdata[CTL_SET0]} : 2'h0;
    // A set written together with a clear of the same output wins
    assign clr_w = wr_ctl ?
        ({wdata[CTL_CLR1], wdata[CTL_CLR0]} & ~set_w) : 2'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tgl_ff <= '0;
        end else begin
            tgl_ff <= ((tgl_ff ^ match) | set_w) & ~clr_w; // RULE15
        end
    end

    assign match_output_zero = tgl_ff[0]; // RULE9
    assign match_output_one = tgl_ff[1]; // RULE10

    // ------------------------------------------------------------
    // Filter clock prescaler
    // ------------------------------------------------------------
    // Shared by all channels; each picks its own tick period.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 7'h01; // RULE11
        end
    end

    // ------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------
    logic [N_CAP-1:0] cap_hit;
    for (genvar c = 0; c < N_CAP; c++) begin : g_cap
        logic [MUX_W-1:0] sel;
        logic raw;
        logic [FSEL_W-1:0] fsel;
        logic [PRE_W-1:0] fmask;
        logic tick;
        logic bypass;
        logic [1:0] edge_sel;
        logic filt_ff;
        logic prev_ff;
        logic [1:0] fcnt_ff;
        logic rise;
        logic fall;

        assign sel = route_ff[c*MUX_W +: MUX_W];
        assign raw = (32'(sel) < N_TRIG) ?
            capture_trigger_input[sel] : 1'b0; // RULE8
        assign fsel = capctl_ff[c][FSEL_LSB +: FSEL_W];
        assign fmask = PRE_W'((8'h01 << fsel) - 8'h01);
        assign tick = ((pre_ff & fmask) == fmask);
        assign bypass = capctl_ff[c][BYPASS_BIT];
        assign edge_sel = capctl_ff[c][EDGE_LSB +: 2];

        // Noise filter: level must hold for three ticks to be taken.
        // Bypass trades noise immunity for single-cycle latency.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                filt_ff <= 1'b0;
                fcnt_ff <= '0;
            end else if (bypass) begin
                filt_ff <= raw;
                fcnt_ff <= '0;
            end else if (tick) begin
                if (raw == filt_ff) begin
                    fcnt_ff <= '0;
                end else if (fcnt_ff == FILT_TICKS - 2'h1) begin
                    filt_ff <= raw; // RULE17
                    fcnt_ff <= '0;
                end else begin
                    fcnt_ff <= fcnt_ff + 2'h1;
                end
            end
        end

        // Edge detection on the filtered level
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                prev_ff <= 1'b0;
            end else begin
                prev_ff <= filt_ff;
            end
        end

        assign rise = filt_ff && !prev_ff;
        assign fall = !filt_ff && prev_ff;
        assign cap_hit[c] = ((edge_sel == EDGE_RISE) && rise) ||
            ((edge_sel == EDGE_FALL) && fall) ||
            ((edge_sel == EDGE_BOTH) && (rise || fall)); // RULE3

        // Every edge overwrites; an unread value is simply lost
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                cap_ff[c] <= '0;
            end else if (cap_hit[c]) begin
                cap_ff[c] <= cnt_ff; // RULE2 RULE16
            end
        end
    end

    // ------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------
    // Registered so every event appears one cycle after its cause.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_ff <= '0;
        end else begin
            evt_ff.overflow <= wrap; // RULE5
            evt_ff.capture <= cap_hit; // RULE4
            evt_ff.match <= match; // RULE6 RULE7
        end
    end

    assign events = evt_ff;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Capture registers have no write decode, so they stay read-only.
    logic [31:0] ctl_rd;
    logic [31:0] capctl0_rd;
    logic [31:0] capctl1_rd;
    logic [31:0] rd_mux;
    assign ctl_rd = 32'(ctl_ff) | (32'(tgl_ff[0]) << CTL_CLR0) |
        (32'(tgl_ff[1]) << CTL_CLR1);
    assign capctl0_rd = {capctl_ff[3], capctl_ff[2],
        capctl_ff[1], capctl_ff[0]};
    assign capctl1_rd = {16'h0000, capctl_ff[5], capctl_ff[4]};
    assign rd_mux = (addr == OFS_CTL) ? ctl_rd :
        (addr == OFS_CAPCTL0) ? capctl0_rd :
        (addr == OFS_CAPCTL1) ? capctl1_rd :
        (addr == OFS_FRT) ? cnt_ff :
        (in_cap && (cap_ofs[1:0] == 2'h0)) ? cap_ff[cap_idx] : // RULE16
        (addr == OFS_CMP0) ? cmp_ff[0] :
        (addr == OFS_CMP1) ? cmp_ff[1] :
        (addr == OFS_MUX) ? 32'(route_ff) :
        32'h0000_0000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else if (rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= '0;
        end
    end

    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// File: common/icct_pkg.sv
// Overview of operation
// RULE1: One free-running 32-bit counter at system clock.
// RULE2: Six capture and two compare registers.
// RULE3: Capture loads count on programmed trigger edge.
// RULE4: Each capture load raises its own event.
// RULE5: Counter wraps to zero, raising overflow event.
// RULE6: Compare zero equality raises match event zero.
// RULE7: Compare one equality raises match event one.
// RULE8: Route select maps any trigger to any capture.
// RULE9: Output pin carries compare zero match state.
// RULE10: Second output pin carries compare one state.
// RULE11: Whole block runs on one clock.
// RULE12: Reset returns all state to defaults.
// RULE13: Low power allowed only while block inactive.
// RULE14: Counter resumes from held value after sleep.
// RULE15: Each compare owns a toggle flip-flop output.
// RULE16: Captures read-only, overwritten on every edge.
// RULE17: Filter changes state after three stable ticks.
// RULE18: Per-channel compare enable gates events, toggles.
// RULE19: Active counter increments by one, else holds.
package icct_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CAPCTL0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CAPCTL1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FRT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CAP0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAP5 = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CMP0 = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_CMP1 = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_MUX = 8'h30;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int N_CAP = 6;
    localparam int N_CMP = 2;
    localparam int CNT_W = 32;
    localparam int CTL_ACT = 0;
    localparam int CTL_CNT_EN = 1;
    localparam int CTL_CMP_EN0 = 2;
    localparam int CTL_CMP_EN1 = 3;
    localparam int CTL_W = 4;
    localparam int CTL_SET1 = 16;
    localparam int CTL_SET0 = 17;
    localparam int CTL_CLR1 = 24;
    localparam int CTL_CLR0 = 25;
    localparam int CAPCTL_W = 8;
    localparam int CAPS_PER_REG = 4;
    localparam int EDGE_LSB = 0;
    localparam int BYPASS_BIT = 2;
    localparam int FSEL_LSB = 5;
    localparam int FSEL_W = 3;
    localparam int MUX_W = 4;
    localparam int PRE_W = 7;
    localparam logic [CAPCTL_W-1:0] CAPCTL_RST = 8'h03;

    // Edge selection codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Filter: input must hold for this many ticks
    localparam logic [1:0] FILT_TICKS = 2'h3;

    // Event bundle, each bit a one-cycle pulse
    typedef struct packed {
        logic overflow;
        logic [N_CAP-1:0] capture;
        logic [N_CMP-1:0] match;
    } icct_evt_s;
endpackage

// File: bench/icct_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
module icct_trig_model (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [3:0] sel, // Pin to flip
    input wire logic go, // Flip request
    output logic [15:0] pins // Trigger pin levels
);
    logic [15:0] pins_ff;
    // Pins move just after an edge, as a synchronous source would
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_ff <= 16'h0000;
        end else if (go) begin
            pins_ff[sel] <= ~pins_ff[sel];
        end
    end
    assign pins = pins_ff;
endmodule
`default_nettype wire

// File: bench/icct_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module icct_timer_checker #(
    parameter int N_TRIG = 16
) (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic [icct_pkg::ADDR_W-1:0] addr, // Address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [31:0] rdata, // Read data
    input wire logic [N_TRIG-1:0] capture_trigger_input, // Pins
    input wire logic sleep_en, // Sleep request
    input wire logic sleep_ok, // Sleep allowed
    input wire logic match_output_zero, // Output 0
    input wire logic match_output_one, // Output 1
    input wire icct_pkg::icct_evt_s events // Events
);
    import icct_pkg::*;
    // ------------------------------------------------------------
    // Quiet-time counter and properties
    // ------------------------------------------------------------
    logic [9:0] quiet_ff;
    logic [N_TRIG-1:0] last_ff;
    // Writes restart it too: a route or edge change can make an edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet_ff <= 10'h000;
            last_ff <= '0;
        end else begin
            last_ff <= capture_trigger_input;
            if (wr || capture_trigger_input != last_ff) begin
                quiet_ff <= 10'h000;
            end else if (quiet_ff != 10'h3ff) begin
                quiet_ff <= quiet_ff + 10'h001;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_sleep_ok_level: assert property (sleep_en |-> sleep_ok)
        else $error("sleep_ok low under sleep request");
    a_zero_match_flip: assert property (
        events.match[0] && !$past(wr) |->
        match_output_zero != $past(match_output_zero))
        else $error("output 0 did not flip on match");
    a_zero_hold_quiet: assert property (
        !events.match[0] && !$past(wr) |->
        $stable(match_output_zero))
        else $error("output 0 moved without match");
    a_one_match_flip: assert property (
        events.match[1] && !$past(wr) |->
        match_output_one != $past(match_output_one))
        else $error("output 1 did not flip on match");
    a_one_hold_quiet: assert property (
        !events.match[1] && !$past(wr) |->
        $stable(match_output_one))
        else $error("output 1 moved without match");
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_ctl_shows_out: assert property (
        rd && addr == OFS_CTL |=>
        rdata[CTL_CLR0] == $past(match_output_zero) &&
        rdata[CTL_CLR1] == $past(match_output_one))
        else $error("control read misreports outputs");
    // Without a sleep request the grant must be the inverse of the activate bit
    a_idle_grant_act: assert property (
        rd && addr == OFS_CTL && !sleep_en |=>
        rdata[CTL_ACT] != $past(sleep_ok))
        else $error("sleep_ok disagrees with activate bit");
    a_no_idle_capture: assert property (
        quiet_ff == 10'h3ff |-> events.capture == '0)
        else $error("capture with quiet pins");
    a_overflow_one_cycle: assert property (
        events.overflow |=> !events.overflow)
        else $error("overflow pulse too long");
    c_overflow: cover property (events.overflow);
    c_capture: cover property (events.capture[5]);
    c_match: cover property (events.match[0] && match_output_zero);
endmodule
bind icct_timer icct_timer_checker #(.N_TRIG(N_TRIG)) icct_timer_checker_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .capture_trigger_input(capture_trigger_input),
    .sleep_en(sleep_en), .sleep_ok(sleep_ok),
    .match_output_zero(match_output_zero),
    .match_output_one(match_output_one), .events(events));
`default_nettype wire

// File: bench/input_capture_compare_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module input_capture_compare_timer_tb_top;
    import icct_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep_en = 1'b0;
    logic go = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdata, v0, v1, v2;
    logic [15:0] pins;
    logic mo0, mo1, sok;
    icct_evt_s events;
    int err_total = 0;
    int cmp_count = 0;
    // ------------------------------------------------------------
    // Clock, instances and bus tasks
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    icct_timer #(.N_TRIG(16)) icct_timer_inst (.clk(clk), .reset_n(reset_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .capture_trigger_input(pins), .sleep_en(sleep_en), .sleep_ok(sok),
        .match_output_zero(mo0), .match_output_one(mo1), .events(events));
    icct_trig_model icct_trig_model_inst (.clk(clk), .reset_n(reset_n),
        .sel(sel), .go(go), .pins(pins));
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data is taken in the only cycle where it stands
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_evt(input int b);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            if (events[b] === 1'b1) return;
        end
        // A missing event is a mismatch and ends the run at once
        chk(32'h0, 32'h1);
        end_sim();
    endtask
    task automatic no_evt(input int b, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk({31'h0, events[b]}, 32'h0);
        end
    endtask
    task automatic flip(input logic [3:0] p);
        @(posedge clk);
        sel <= p;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    // Main sequence; counter figures assume one step per clock
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(OFS_CTL, v0);
        chk(v0, 32'h0);
        rd_reg(OFS_CAPCTL0, v0);
        chk(v0, {4{CAPCTL_RST}});
        rd_reg(OFS_CAPCTL1, v0);
        chk(v0, {16'h0, {2{CAPCTL_RST}}});
        rd_reg(OFS_FRT, v0);
        chk(v0, 32'h0);
        rd_reg(8'h34, v0);
        chk(v0, 32'h0);
        wr_reg(OFS_CTL, 32'h3);
        rd_reg(OFS_FRT, v0);
        rd_reg(OFS_FRT, v1);
        chk(v1 - v0, 32'h2);
        chk({31'h0, sok}, 32'h0);
        @(posedge clk);
        sleep_en <= 1'b1;
        rd_reg(OFS_FRT, v0);
        rd_reg(OFS_FRT, v1);
        chk(v1 - v0, 32'h0);
        chk({31'h0, sok}, 32'h1);
        v2 = v1;
        @(posedge clk);
        sleep_en <= 1'b0;
        rd_reg(OFS_FRT, v0);
        rd_reg(OFS_FRT, v1);
        chk(v1 - v0, 32'h2);
        chk(v0 - v2, 32'h1);
        wr_reg(OFS_FRT, 32'hffff_fff0);
        wait_evt(8);
        rd_reg(OFS_FRT, v0);
        chk(v0, 32'h1);
        wr_reg(OFS_CMP0, 32'h40);
        wr_reg(OFS_CMP1, 32'h41);
        wr_reg(OFS_FRT, 32'h0);
        wr_reg(OFS_CTL, 32'hf);
        wait_evt(0);
        chk({31'h0, mo0}, 32'h1);
        @(posedge clk);
        #1;
        chk({30'h0, events[1], mo1}, 32'h3);
        wr_reg(OFS_CTL, 32'h3);
        wr_reg(OFS_FRT, 32'h0);
        no_evt(0, 80);
        chk({31'h0, mo0}, 32'h1);
        wr_reg(OFS_CTL, 32'h0300_0003);
        rd_reg(OFS_CTL, v0);
        chk(v0 & 32'h0300_000f, 32'h3);
        wr_reg(OFS_CTL, 32'h0002_0003);
        rd_reg(OFS_CTL, v0);
        chk(v0 & 32'h0300_000f, 32'h0200_0003);
        wr_reg(OFS_MUX, 32'h00b9_7531);
        rd_reg(OFS_MUX, v0);
        chk(v0, 32'h00b9_7531);
        wr_reg(OFS_CAPCTL0, 32'h0505_0505);
        wr_reg(OFS_CAPCTL1, 32'h0000_0505);
        for (int c = 0; c < 6; c++) begin
            rd_reg(OFS_FRT, v0);
            flip(4'(2 * c + 1));
            wait_evt(2 + c);
            rd_reg(OFS_CAP0 + 8'(4 * c), v1);
            // Pin flips two edges after the read, bypass adds two more
            chk(v1 - v0, 32'h4);
            flip(4'(2 * c + 1));
            no_evt(2 + c, 10);
        end
        wr_reg(OFS_CAPCTL0, 32'h0505_0501);
        flip(4'h1);
        flip(4'h1);
        no_evt(2, 12);
        flip(4'h1);
        wait_evt(2);
        rd_reg(OFS_CAP0, v0);
        wr_reg(OFS_CAP0, 32'h0);
        rd_reg(OFS_CAP0, v1);
        chk(v1, v0);
        // Falling-only on channel 4, both edges on channel 5
        wr_reg(OFS_CAPCTL1, 32'h0000_0604);
        flip(4'h9);
        no_evt(6, 6);
        flip(4'h9);
        wait_evt(6);
        flip(4'hb);
        wait_evt(7);
        flip(4'hb);
        wait_evt(7);
        // Mid-run reset must clear state that is far from its default
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk({30'h0, mo1, mo0}, 32'h0);
        rd_reg(OFS_MUX, v0);
        chk(v0, 32'h0);
        rd_reg(OFS_CAP0, v0);
        chk(v0, 32'h0);
        repeat (1100) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
